// ==== core/ccu_clock_ctrl.sv ====
// Clock source select, start-up timing, trim load and clock domain gating
//
// Chosen here: the register addresses and the Wishbone register port.
`timescale 1ns/10ps
module ccu_clock_ctrl #(
  parameter int unsigned CNT_W          = 16,
  parameter int unsigned WDT_SHORT_CYC  = ccu_pkg::WDT_CYC_SHORT,
  parameter int unsigned WDT_LONG_CYC   = ccu_pkg::WDT_CYC_LONG,
  parameter int unsigned WAKE_16K_CYC   = ccu_pkg::WAKE_CK_16K,
  parameter int unsigned WAKE_32K_CYC   = ccu_pkg::WAKE_CK_32K
) (
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire ccu_pkg::ccu_fuses_t fuses,
  input  wire logic [7:0]        factory_cal,
  input  wire logic              src_tick,
  input  wire logic              wdt_tick,
  input  wire logic              sleep_req,
  input  wire logic [2:0]        sleep_mode,
  input  wire logic              wake_req,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  output ccu_pkg::ccu_gates_t    gates,
  output logic                   cpu_run,
  output logic [7:0]             rc_calibration_register,
  output logic [3:0]             presc_shift,
  output logic                   config_error
);

  if (CNT_W < 16 || CNT_W > 24) begin : g_bad_w
    $error("Counter width must be 16 to 24");
  end
  // A watchdog count equal to 2**CNT_W would wrap to zero and skip the delay
  if (WDT_LONG_CYC >= 2**CNT_W || WAKE_32K_CYC >= 2**CNT_W ||
      WDT_SHORT_CYC >= 2**CNT_W || WAKE_16K_CYC >= 2**CNT_W ||
      WDT_SHORT_CYC == 0 || WDT_LONG_CYC == 0 ||
      WAKE_16K_CYC == 0 || WAKE_32K_CYC == 0) begin : g_bad_cnt
    $error("Delay counts must be nonzero and fit the counter");
  end

  typedef logic [CNT_W-1:0] ccu_cnt_t;

  typedef struct packed {
    ccu_pkg::ccu_state_t st;
    ccu_cnt_t            cnt;
    ccu_pkg::ccu_fuses_t fz;
    logic [7:0]          trim;
    logic [3:0]          presc;
    logic                cfg_err;
    logic [2:0]          smode;
    ccu_pkg::ccu_gates_t g;
    logic                ack;
    logic [31:0]         rdat;
  } ccu_regs_t;

  ccu_regs_t r_ff;
  ccu_regs_t nxt_r;

  localparam ccu_cnt_t CK14   = ccu_cnt_t'(ccu_pkg::RESET_CK_CYC);
  localparam ccu_cnt_t WD_S   = ccu_cnt_t'(WDT_SHORT_CYC);
  localparam ccu_cnt_t WD_L   = ccu_cnt_t'(WDT_LONG_CYC);

  // Shipped fuse image; only fills the state until the first load
  localparam ccu_pkg::ccu_fuses_t SHIPPED_FZ = '{
    src_sel: ccu_pkg::SRC_RC_8MHZ, startup_time_fuses: ccu_pkg::SUT_LONG,
    div8_n: ccu_pkg::FUSE_PROGRAMMED, rstdis_n: 1'b1};

  // Codes 0001, 0011, 0101, 0111 and start-up 11 on simple sources
  function automatic logic fuse_bad(input ccu_pkg::ccu_fuses_t f);
    logic simple;
    simple = ~f.src_sel[3];
    fuse_bad = (simple & f.src_sel[0]) |
               (simple & (f.startup_time_fuses == ccu_pkg::SUT_RESERVED));
  endfunction

  // Watchdog ticks of the real-time part of the reset delay
  function automatic ccu_cnt_t rst_wdt(input ccu_pkg::ccu_fuses_t f);
    logic [2:0] xc;
    xc = {f.src_sel[0], f.startup_time_fuses};
    rst_wdt = '0;
    if (f.src_sel[3]) begin
      unique case (xc)
        3'h0, 3'h3, 3'h6: rst_wdt = WD_S;
        3'h1, 3'h4, 3'h7: rst_wdt = WD_L;
        default:          rst_wdt = '0;
      endcase
    end else if (f.src_sel == ccu_pkg::SRC_LF_CRYSTAL) begin
      rst_wdt = (f.startup_time_fuses == ccu_pkg::SUT_SHORT) ? WD_S : WD_L;
    end else begin
      unique case (f.startup_time_fuses)
        ccu_pkg::SUT_SHORT: begin
          // Lets programming mode be entered without a reset pin
          if (f.src_sel != ccu_pkg::SRC_EXT_CLOCK &&
              f.rstdis_n == ccu_pkg::FUSE_PROGRAMMED) begin
            rst_wdt = WD_S;
          end
        end
        ccu_pkg::SUT_MEDIUM: rst_wdt = WD_S;
        ccu_pkg::SUT_LONG:   rst_wdt = WD_L;
        default:             rst_wdt = '0;
      endcase
    end
  endfunction

  // Source clocks counted on power-down wake
  function automatic ccu_cnt_t wake_ck(input ccu_pkg::ccu_fuses_t f);
    wake_ck = ccu_cnt_t'(ccu_pkg::WAKE_CK_FAST);
    if (f.src_sel[3]) begin
      if (!f.src_sel[0]) begin
        wake_ck = f.startup_time_fuses[1] ? ccu_cnt_t'(ccu_pkg::WAKE_CK_1K)
                           : ccu_cnt_t'(ccu_pkg::WAKE_CK_258);
      end else begin
        wake_ck = (f.startup_time_fuses == ccu_pkg::SUT_SHORT)
                ? ccu_cnt_t'(ccu_pkg::WAKE_CK_1K)
                : ccu_cnt_t'(WAKE_16K_CYC);
      end
    end else if (f.src_sel == ccu_pkg::SRC_LF_CRYSTAL) begin
      wake_ck = (f.startup_time_fuses == ccu_pkg::SUT_LONG) ? ccu_cnt_t'(WAKE_32K_CYC)
                                             : ccu_cnt_t'(ccu_pkg::WAKE_CK_1K);
    end
  endfunction

  logic     bus_req;
  ccu_cnt_t wdt_target;
  ccu_cnt_t wake_target;

  assign bus_req     = wb_cyc_i & wb_stb_i;
  assign wdt_target  = rst_wdt(r_ff.fz);
  assign wake_target = wake_ck(r_ff.fz);

  always_comb begin
    nxt_r      = r_ff;
    nxt_r.ack  = bus_req & ~r_ff.ack;
    nxt_r.rdat = 32'h0;
    unique case (r_ff.st)
      ccu_pkg::CCU_LOAD: begin
        nxt_r.fz    = fuses;
        nxt_r.trim  = factory_cal;
        nxt_r.presc = (fuses.div8_n == ccu_pkg::FUSE_PROGRAMMED)
                    ? ccu_pkg::PRESC_DIV8 : ccu_pkg::PRESC_DIV1;
        nxt_r.cfg_err = fuse_bad(fuses);
        nxt_r.cnt     = '0;
        nxt_r.st = fuse_bad(fuses) ? ccu_pkg::CCU_HALT
                                   : ccu_pkg::CCU_RST_CK;
      end
      ccu_pkg::CCU_RST_CK: begin
        if (src_tick) begin
          if (r_ff.cnt == CK14 - 1'b1) begin
            nxt_r.cnt = '0;
            nxt_r.st  = ccu_pkg::CCU_RST_WDT;
          end else begin
            nxt_r.cnt = r_ff.cnt + 1'b1;
          end
        end
      end
      ccu_pkg::CCU_RST_WDT: begin
        if (wdt_target == '0) begin
          nxt_r.st = ccu_pkg::CCU_RUN;
        end else if (wdt_tick) begin
          if (r_ff.cnt == wdt_target - 1'b1) begin
            nxt_r.cnt = '0;
            nxt_r.st  = ccu_pkg::CCU_RUN;
          end else begin
            nxt_r.cnt = r_ff.cnt + 1'b1;
          end
        end
      end
      ccu_pkg::CCU_RUN: begin
        if (sleep_req) begin
          nxt_r.smode = sleep_mode;
          nxt_r.st    = ccu_pkg::CCU_SLEEP;
        end
      end
      ccu_pkg::CCU_SLEEP: begin
        if (wake_req) begin
          nxt_r.cnt = '0;
          // Only power-down stops the oscillator, so only it restarts slow
          nxt_r.st  = (r_ff.smode == ccu_pkg::SLP_POWER_DOWN)
                    ? ccu_pkg::CCU_WAKE : ccu_pkg::CCU_RUN;
        end
      end
      ccu_pkg::CCU_WAKE: begin
        if (src_tick) begin
          if (r_ff.cnt == wake_target - 1'b1) begin
            nxt_r.cnt = '0;
            nxt_r.st  = ccu_pkg::CCU_RUN;
          end else begin
            nxt_r.cnt = r_ff.cnt + 1'b1;
          end
        end
      end
      ccu_pkg::CCU_HALT: begin
        nxt_r.st = ccu_pkg::CCU_HALT;
      end
      default: begin
        nxt_r.st = ccu_pkg::CCU_HALT;
      end
    endcase
    // Write lands on the edge where the master sees ack
    if (bus_req & wb_we_i & r_ff.ack & wb_sel_i[0]) begin
      if (wb_adr_i == ccu_pkg::REG_CAL) begin
        nxt_r.trim = wb_dat_i[7:0];
      end else if (wb_adr_i == ccu_pkg::REG_PRESC) begin
        nxt_r.presc = wb_dat_i[3:0];
      end
    end
    if (bus_req & ~r_ff.ack & ~wb_we_i) begin
      unique case (wb_adr_i)
        ccu_pkg::REG_CAL:   nxt_r.rdat[7:0] = r_ff.trim;
        ccu_pkg::REG_PRESC: nxt_r.rdat[3:0] = r_ff.presc;
        ccu_pkg::REG_STATUS: begin
          nxt_r.rdat[ccu_pkg::STAT_STATE_LSB +: 3] = r_ff.st;
          nxt_r.rdat[ccu_pkg::STAT_ERR_BIT]        = r_ff.cfg_err;
          nxt_r.rdat[ccu_pkg::STAT_SRC_LSB +: 4]   = r_ff.fz.src_sel;
          nxt_r.rdat[ccu_pkg::STAT_SUT_LSB +: 2]   = r_ff.fz.startup_time_fuses;
          nxt_r.rdat[ccu_pkg::STAT_DIV8_BIT]       = r_ff.fz.div8_n;
          nxt_r.rdat[ccu_pkg::STAT_RSTD_BIT]       = r_ff.fz.rstdis_n;
        end
        default: nxt_r.rdat = 32'h0;
      endcase
    end
    // Gates follow the next state so outputs stay pure flops
    nxt_r.g.core_en   = (nxt_r.st == ccu_pkg::CCU_RUN);
    nxt_r.g.flash_en  = nxt_r.g.core_en;
    nxt_r.g.periph_en = nxt_r.g.core_en |
                        ((nxt_r.st == ccu_pkg::CCU_SLEEP) &
                         (nxt_r.smode == ccu_pkg::SLP_IDLE));
    nxt_r.g.conv_en   = nxt_r.g.periph_en |
                        ((nxt_r.st == ccu_pkg::CCU_SLEEP) &
                         (nxt_r.smode == ccu_pkg::SLP_ADC_NR));
    nxt_r.g.async_det = ~nxt_r.g.periph_en;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      r_ff <= '{st: ccu_pkg::CCU_LOAD, cnt: '0, fz: SHIPPED_FZ,
                trim: ccu_pkg::CAL_RESET, presc: ccu_pkg::PRESC_DIV1,
                cfg_err: 1'b0, smode: ccu_pkg::SLP_IDLE,
                g: 5'h01, ack: 1'b0, rdat: 32'h0};
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign wb_dat_o                = r_ff.rdat;
  assign wb_ack_o                = r_ff.ack;
  assign gates                   = r_ff.g;
  assign cpu_run                 = r_ff.g.core_en;
  assign rc_calibration_register = r_ff.trim;
  assign presc_shift             = r_ff.presc;
  assign config_error            = r_ff.cfg_err;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_wake_start;
    r_ff.st == ccu_pkg::CCU_SLEEP && wake_req &&
    r_ff.smode == ccu_pkg::SLP_POWER_DOWN;
  endsequence
  sequence s_wake_hold;
    !cpu_run [*2];
  endsequence

  chk_core_halted: assert property (
    r_ff.st != ccu_pkg::CCU_RUN |-> !cpu_run)
    else $error("Core clock on outside run");
  chk_flash_core: assert property (gates.flash_en == gates.core_en)
    else $error("Flash clock differs from core clock");
  // Checked on leaving load: the release edge itself still sees reset
  chk_trim_load: assert property (
    $past(r_ff.st) == ccu_pkg::CCU_LOAD && r_ff.st != ccu_pkg::CCU_LOAD |->
    rc_calibration_register == $past(factory_cal))
    else $error("Factory trim not loaded");
  chk_trim_write: assert property (wb_cyc_i && wb_stb_i && wb_we_i &&
    wb_ack_o && wb_sel_i[0] && wb_adr_i == ccu_pkg::REG_CAL |=>
    rc_calibration_register == $past(wb_dat_i[7:0]))
    else $error("Calibration write lost");
  chk_fuse_frozen: assert property (r_ff.st != ccu_pkg::CCU_LOAD |=>
    $stable(r_ff.fz))
    else $error("Fuses changed after reset");
  chk_reserved_halt: assert property (config_error |->
    r_ff.st == ccu_pkg::CCU_HALT && !cpu_run)
    else $error("Reserved code did not halt");
  chk_div8_start: assert property (
    $past(r_ff.st) == ccu_pkg::CCU_LOAD && r_ff.st != ccu_pkg::CCU_LOAD |->
    presc_shift == (($past(fuses.div8_n) == ccu_pkg::FUSE_PROGRAMMED)
                    ? ccu_pkg::PRESC_DIV8 : ccu_pkg::PRESC_DIV1))
    else $error("Prescaler start value wrong");
  chk_wdt_only: assert property (r_ff.st == ccu_pkg::CCU_RST_WDT &&
    !wdt_tick && wdt_target != '0 |=> $stable(r_ff.cnt))
    else $error("Reset delay counted without watchdog tick");
  chk_adc_sleep: assert property (r_ff.st == ccu_pkg::CCU_SLEEP &&
    r_ff.smode == ccu_pkg::SLP_ADC_NR |->
    gates.conv_en && !gates.periph_en)
    else $error("Converter clock wrong in noise reduction");
  chk_async_irq: assert property (
    !gates.periph_en |-> gates.async_det)
    else $error("Async detect off while peripheral clock off");
  chk_wake_delay: assert property (s_wake_start |=> s_wake_hold)
    else $error("Core ran before wake delay");

endmodule

// ==== inc/ccu_pkg.sv ====
// Constants, state codes and register layout of the clock control unit
package ccu_pkg;

  // Source select codes; fuse bits read low when programmed
  localparam logic [3:0] SRC_EXT_CLOCK   = 4'h0;
  localparam logic [3:0] SRC_RC_8MHZ     = 4'h2;
  localparam logic [3:0] SRC_RC_128KHZ   = 4'h4;
  localparam logic [3:0] SRC_LF_CRYSTAL  = 4'h6;
  localparam logic       FUSE_PROGRAMMED = 1'h0;

  // Start-up field codes
  localparam logic [1:0] SUT_SHORT    = 2'h0;
  localparam logic [1:0] SUT_MEDIUM   = 2'h1;
  localparam logic [1:0] SUT_LONG     = 2'h2;
  localparam logic [1:0] SUT_RESERVED = 2'h3;

  // Delays; the real-time parts are counted on watchdog oscillator ticks
  localparam int unsigned T_SHORT_MS      = 4;
  localparam int unsigned T_LONG_MS       = 64;
  localparam int unsigned WDT_CYC_SHORT   = 512;
  localparam int unsigned WDT_CYC_LONG    = 8192;
  localparam int unsigned RESET_CK_CYC    = 14;
  localparam int unsigned WAKE_CK_FAST    = 6;
  localparam int unsigned WAKE_CK_258     = 258;
  localparam int unsigned WAKE_CK_1K      = 1024;
  localparam int unsigned WAKE_CK_16K     = 16384;
  localparam int unsigned WAKE_CK_32K     = 32768;

  // Prescaler shift codes: divide by 2**code
  localparam logic [3:0] PRESC_DIV1 = 4'h0;
  localparam logic [3:0] PRESC_DIV8 = 4'h3;

  // Sleep modes
  localparam logic [2:0] SLP_IDLE       = 3'h0;
  localparam logic [2:0] SLP_ADC_NR     = 3'h1;
  localparam logic [2:0] SLP_POWER_DOWN = 3'h2;
  localparam logic [2:0] SLP_STANDBY    = 3'h3;

  // Register byte offsets and status fields
  localparam logic [7:0] REG_CAL    = 8'h00;
  localparam logic [7:0] REG_PRESC  = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam int unsigned STAT_STATE_LSB = 0;
  localparam int unsigned STAT_ERR_BIT   = 3;
  localparam int unsigned STAT_SRC_LSB   = 4;
  localparam int unsigned STAT_SUT_LSB   = 8;
  localparam int unsigned STAT_DIV8_BIT  = 10;
  localparam int unsigned STAT_RSTD_BIT  = 11;
  localparam logic [7:0] CAL_RESET = 8'h00;

  typedef enum logic [2:0] {
    CCU_LOAD    = 3'h0,
    CCU_RST_CK  = 3'h1,
    CCU_RST_WDT = 3'h3,
    CCU_RUN     = 3'h2,
    CCU_SLEEP   = 3'h6,
    CCU_WAKE    = 3'h7,
    CCU_HALT    = 3'h5
  } ccu_state_t;

  typedef struct packed {
    logic [3:0] src_sel;
    logic [1:0] startup_time_fuses;
    logic       div8_n;
    logic       rstdis_n;
  } ccu_fuses_t;

  typedef struct packed {
    logic core_en;
    logic periph_en;
    logic flash_en;
    logic conv_en;
    logic async_det;
  } ccu_gates_t;

endpackage

// ==== sim/ccu_osc_model.sv ====
// Model of the selected clock source and the watchdog oscillator
`timescale 1ns/10ps
module ccu_osc_model #(
  parameter int unsigned SRC_DIV = 2,
  parameter int unsigned WDT_DIV = 4
) (
  input  wire logic ref_clk,
  input  wire logic resetn,
  output logic      src_tick,
  output logic      wdt_tick
);
  logic [7:0] src_cnt_ff;
  logic [7:0] wdt_cnt_ff;

  // Fixed periods: the source never steps in frequency outside reset
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      src_cnt_ff <= 8'h00;
      wdt_cnt_ff <= 8'h00;
    end else begin
      src_cnt_ff <= (src_cnt_ff == 8'(SRC_DIV - 1)) ? 8'h00
                                                    : src_cnt_ff + 8'h01;
      wdt_cnt_ff <= (wdt_cnt_ff == 8'(WDT_DIV - 1)) ? 8'h00
                                                    : wdt_cnt_ff + 8'h01;
    end
  end

  assign src_tick = (src_cnt_ff == 8'(SRC_DIV - 1));
  // Watchdog ticks keep their own rate whatever source is chosen
  assign wdt_tick = (wdt_cnt_ff == 8'(WDT_DIV - 1));
endmodule

// ==== sim/tb_top.sv ====
// Self-checking bench of the clock control unit
`timescale 1ns/10ps
module tb_top;
  logic                ref_clk = 1'b0;
  logic                resetn = 1'b0;
  ccu_pkg::ccu_fuses_t fuses = 8'h29;
  logic [7:0]          factory_cal = 8'h00;
  logic                src_tick, wdt_tick;
  logic                sleep_req = 1'b0, wake_req = 1'b0;
  logic [2:0]          sleep_mode = 3'h0;
  logic                wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [7:0]          wb_adr = 8'h00;
  logic [3:0]          wb_sel = 4'h0;
  logic [31:0]         wb_dat = 32'h0, wb_rdat, rd;
  logic                wb_ack, cpu_run, config_error;
  ccu_pkg::ccu_gates_t gates;
  logic [7:0]          cal;
  logic [3:0]          presc_shift;
  int                  n_errors = 0, total_checks = 0, cycles = 0;

  always #10 ref_clk = ~ref_clk;

  ccu_osc_model i_osc (.ref_clk(ref_clk), .resetn(resetn),
    .src_tick(src_tick), .wdt_tick(wdt_tick));

  ccu_clock_ctrl #(.WDT_SHORT_CYC(8), .WDT_LONG_CYC(16),
    .WAKE_16K_CYC(20), .WAKE_32K_CYC(24)) i_dut (
    .ref_clk(ref_clk), .resetn(resetn), .fuses(fuses),
    .factory_cal(factory_cal), .src_tick(src_tick), .wdt_tick(wdt_tick),
    .sleep_req(sleep_req), .sleep_mode(sleep_mode), .wake_req(wake_req),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .gates(gates),
    .cpu_run(cpu_run), .rc_calibration_register(cal),
    .presc_shift(presc_shift), .config_error(config_error));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  // One classic cycle; ack is sampled at the edge, before it updates
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    wb_sel <= s;
    do begin
      @(posedge ref_clk);
    end while (wb_ack !== 1'b1);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Boot with given fuses; n is watchdog ticks after 14 source clocks
  task automatic t_boot(input logic [7:0] fz, input int n,
                        input logic [3:0] ps);
    int t;
    int ck;
    resetn <= 1'b0;
    fuses <= fz;
    factory_cal <= fz ^ 8'h5a;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    t = 0;
    while (cpu_run !== 1'b1 && t < 200) begin
      @(posedge ref_clk);
      t++;
    end
    check(32'(config_error), 32'(n < 0));
    if (n >= 0) begin
      // Two ref clocks per source tick, four per watchdog tick
      ck = 2 * ccu_pkg::RESET_CK_CYC + 4 * n;
      check(32'(t >= ck + 1 && t <= ck + 2), 32'h1);
      check(32'(presc_shift), 32'(ps));
      check(32'(cal), 32'(fz ^ 8'h5a));
    end
    // Reserved code after boot must not disturb a running core
    fuses <= 8'h13;
    repeat (10) @(posedge ref_clk);
    check(32'(cpu_run), 32'(n >= 0));
    $display("test boot %h done", fz);
  endtask

  task automatic t_regs();
    wb(1'b1, ccu_pkg::REG_CAL, 32'h0000_00a5, 4'hf);
    check(32'(cal), 32'h0000_00a5);
    wb(1'b1, ccu_pkg::REG_CAL, 32'h0000_0011, 4'h0);
    wb(1'b0, ccu_pkg::REG_CAL, 32'h0, 4'hf);
    check(rd, 32'h0000_00a5);
    wb(1'b0, 8'h40, 32'h0, 4'hf);
    check(rd, 32'h0);
    wb(1'b0, ccu_pkg::REG_STATUS, 32'h0, 4'hf);
    check(32'(rd[7:0]), 32'h0000_0022);
    $display("test regs done");
  endtask

  task automatic t_sleep();
    logic [2:0] m[4] = '{3'h0, 3'h1, 3'h3, 3'h2};
    logic [4:0] g[4] = '{5'h0a, 5'h03, 5'h01, 5'h01};
    int t;
    for (int i = 0; i < 4; i++) begin
      sleep_mode <= m[i];
      sleep_req <= 1'b1;
      @(posedge ref_clk);
      sleep_req <= 1'b0;
      repeat (2) @(posedge ref_clk);
      check(32'(gates), 32'(g[i]));
      check(32'(cpu_run), 32'h0);
      wake_req <= 1'b1;
      @(posedge ref_clk);
      wake_req <= 1'b0;
      t = 1;
      while (cpu_run !== 1'b1 && t < 100) begin
        @(posedge ref_clk);
        t++;
      end
      // Only power-down waits, two ref clocks per source clock
      if (m[i] == ccu_pkg::SLP_POWER_DOWN) begin
        check(32'(t >= 2 * ccu_pkg::WAKE_CK_FAST + 1 &&
                  t <= 2 * ccu_pkg::WAKE_CK_FAST + 2), 32'h1);
      end else begin
        check(32'(t), 32'h2);
      end
      @(posedge ref_clk);
      check(32'(gates), 32'h1e);
    end
    $display("test sleep done");
  endtask

  initial begin
    t_boot(8'h02, 0, 4'h0);
    t_boot(8'h07, 8, 4'h0);
    t_boot(8'h42, 8, 4'h0);
    t_boot(8'h23, 0, 4'h0);
    t_boot(8'h63, 8, 4'h0);
    t_boot(8'h13, -1, 4'h0);
    t_boot(8'h4f, -1, 4'h0);
    t_boot(8'h8b, 0, 4'h0);
    t_boot(8'h9f, 16, 4'h0);
    t_boot(8'h29, 16, 4'h3);
    t_regs();
    t_sleep();
    tally_and_finish();
  end
endmodule
